// ---- rtl/frequency_load_shedding_control.sv ----
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module frequency_load_shedding_control
    import fls_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] contact_inputs,
    input wire meas_t meas_va,
    input wire meas_t meas_vab,
    input wire logic [15:0] rate_of_change,
    input wire logic half_cycle_tick,
    input wire logic cycle_tick,
    input wire logic breaker_open_status,
    input wire logic trip_circuit_supervision_failure,
    output logic [2:0] element_trip,
    output logic frequency_elements_blocked,
    output logic open_cmd,
    output logic close_cmd,
    output logic close_command_annulled,
    output logic irq
);
    // reset release through two flops
    logic rst_meta_b;
    logic rst_sync_b;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // mapped contact picked by a 4-bit selector: bit3 enables, bits 2:0 index
    function automatic logic pick_contact(input logic [7:0] contacts, input logic [3:0] sel);
        pick_contact = sel[3] & contacts[sel[2:0]];
    endfunction

    // software registers
    ctrl_t ctrl;
    logic [11:0] blk_sel;
    logic [15:0] uv_set;
    logic [4:0] act_half;
    logic [3:0] reset_cyc;
    logic [15:0] of1_set;
    logic [15:0] uf1_set;
    logic [15:0] roc1_freq;
    logic [15:0] roc1_rate;
    logic [3:0] int_stat;
    logic [3:0] int_mask;

    // apb decode, zero wait states
    wire wr_en = psel & penable & pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_blk = paddr == OFS_BLK_SEL;
    wire hit_uv = paddr == OFS_UV_SET;
    wire hit_tim = paddr == OFS_TIMING;
    wire hit_of = paddr == OFS_OF1_SET;
    wire hit_uf = paddr == OFS_UF1_SET;
    wire hit_roc = paddr == OFS_ROC1_SET;
    wire hit_stat = paddr == OFS_STATUS;
    wire hit_ist = paddr == OFS_INT_STAT;
    wire hit_imk = paddr == OFS_INT_MASK;
    wire hit_any = hit_ctrl | hit_blk | hit_uv | hit_tim | hit_of | hit_uf | hit_roc | hit_stat | hit_ist | hit_imk;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ctrl <= ctrl_t'(RST_CTRL);
            blk_sel <= RST_BLK_SEL;
            uv_set <= RST_UV_SET;
            act_half <= RST_ACT_HALF;
            reset_cyc <= RST_RESET_CYC;
            of1_set <= RST_OF1_SET;
            uf1_set <= RST_UF1_SET;
            roc1_freq <= RST_ROC1_FREQ;
            roc1_rate <= RST_ROC1_RATE;
            int_mask <= RST_INT;
        end
        else if (wr_en)
        begin
            if (hit_ctrl) ctrl <= ctrl_t'(pwdata[6:0]);
            if (hit_blk) blk_sel <= pwdata[11:0];
            if (hit_uv) uv_set <= pwdata[15:0];
            if (hit_tim) act_half <= pwdata[4:0];
            if (hit_tim) reset_cyc <= pwdata[TIM_RESET_LSB +: 4];
            if (hit_of) of1_set <= pwdata[15:0];
            if (hit_uf) uf1_set <= pwdata[15:0];
            if (hit_roc) roc1_freq <= pwdata[15:0];
            if (hit_roc) roc1_rate <= pwdata[ROC_RATE_LSB +: 16];
            if (hit_imk) int_mask <= pwdata[3:0];
        end
    end

    // measurement source: the side that keeps voltage after shedding
    meas_t meas;
    assign meas = ctrl.freq_src_vab ? meas_vab : meas_va;

    // voltage too low to measure any frequency
    wire below_min = meas.voltage < MIN_FREQ_VOLTAGE;

    // undervoltage supervisor with hysteresis and a stability count
    logic uv_pick;
    logic [3:0] uv_cnt;
    wire uv_at_pickup = meas.voltage <= uv_set;
    wire [20:0] v_scaled = {5'h00, meas.voltage} * {16'h0000, UV_BASE_PCT};
    wire [20:0] set_scaled = {5'h00, uv_set} * {16'h0000, UV_RESET_PCT};
    wire uv_above_reset = v_scaled >= set_scaled;
    // held picked up out of reset so nothing trips before voltage is proven stable
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            uv_pick <= 1'b1;
            uv_cnt <= 4'h0;
        end
        else if (uv_at_pickup)
        begin
            uv_pick <= 1'b1;
            uv_cnt <= 4'h0;
        end
        else if (!uv_above_reset)
            uv_cnt <= 4'h0; // any dip restarts the count
        else if (uv_pick && uv_cnt == UV_RESET_CYCLES)
        begin
            uv_pick <= 1'b0;
            uv_cnt <= 4'h0;
        end
        else if (uv_pick && cycle_tick)
            uv_cnt <= uv_cnt + 4'h1;
    end

    wire inhibit = uv_pick | below_min;
    assign frequency_elements_blocked = inhibit;

    // load shedding state; the latched shed trip leaves this module only through the status register
    ls_state_t state;
    wire shed_latched = state == LS_SHED;
    wire shed_mode = ctrl.shed_en;

    // per-element blocking, pickup and clear conditions
    wire [2:0] elem_block;
    wire [2:0] set_cond;
    wire [2:0] clr_cond;
    wire [2:0] gate;
    wire [4:0] act_roc = act_half < ROC_MIN_HALF ? ROC_MIN_HALF : act_half;
    assign set_cond[EL_OF] = meas.freq >= of1_set;
    assign clr_cond[EL_OF] = meas.freq < of1_set - FREQ_HYST;
    assign set_cond[EL_UF] = meas.freq <= uf1_set;
    assign clr_cond[EL_UF] = meas.freq > uf1_set + FREQ_HYST;
    assign set_cond[EL_ROC] = (meas.freq <= roc1_freq) && ($signed(rate_of_change) <= $signed(roc1_rate));
    assign clr_cond[EL_ROC] = !set_cond[EL_ROC];
    // with shedding enabled, overfrequency 1 only runs while the shed trip is latched and the breaker is open
    wire of_shed_gate = !shed_mode || (shed_latched && breaker_open_status);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EL; gi++)
        begin : g_el
            logic [4:0] pk_cnt;
            logic [3:0] rs_cnt;
            wire [4:0] need = gi == EL_ROC ? act_roc : act_half;
            assign elem_block[gi] = pick_contact(contact_inputs, blk_sel[4*gi +: 4]);
            assign gate[gi] = ctrl.elem_en[gi] & ~elem_block[gi] & ~inhibit & (gi != EL_OF || of_shed_gate);
            // losing the gate clears the trip, which covers late blocking and latch release
            always_ff @(posedge clk_sys or negedge rst_sync_b)
            begin
                if (!rst_sync_b)
                begin
                    element_trip[gi] <= 1'b0;
                    pk_cnt <= 5'h00;
                    rs_cnt <= 4'h0;
                end
                else if (!gate[gi])
                begin
                    element_trip[gi] <= 1'b0;
                    pk_cnt <= 5'h00;
                    rs_cnt <= 4'h0;
                end
                else if (!element_trip[gi])
                begin
                    rs_cnt <= 4'h0;
                    if (!set_cond[gi])
                        pk_cnt <= 5'h00;
                    else if (pk_cnt >= need)
                        element_trip[gi] <= 1'b1;
                    else if (half_cycle_tick)
                        pk_cnt <= pk_cnt + 5'h01;
                end
                else if (!clr_cond[gi])
                    rs_cnt <= 4'h0;
                else if (rs_cnt >= reset_cyc)
                begin
                    element_trip[gi] <= 1'b0;
                    pk_cnt <= 5'h00;
                    rs_cnt <= 4'h0;
                end
                else if (cycle_tick)
                    rs_cnt <= rs_cnt + 4'h1;
            end
        end
    endgenerate

    // controller: rising edge of the chosen shed trip opens, overfrequency 1 restores
    logic shed_prev;
    logic of_prev;
    wire shed_src = ctrl.shed_type_roc ? element_trip[EL_ROC] : element_trip[EL_UF];
    wire permit = ctrl.switching_permission & ~frequency_elements_blocked;
    wire shed_go = shed_mode && permit && shed_src && !shed_prev;
    wire close_due = permit && element_trip[EL_OF] && !of_prev && breaker_open_status;
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state <= LS_IDLE;
            shed_prev <= 1'b0;
            of_prev <= 1'b0;
            open_cmd <= 1'b0;
            close_cmd <= 1'b0;
            close_command_annulled <= 1'b0;
        end
        else
        begin
            shed_prev <= shed_src;
            of_prev <= element_trip[EL_OF];
            open_cmd <= 1'b0;
            close_cmd <= 1'b0;
            close_command_annulled <= 1'b0;
            case (state)
                LS_IDLE:
                begin
                    if (shed_go)
                    begin
                        open_cmd <= 1'b1;
                        state <= LS_SHED;
                    end
                end
                LS_SHED:
                begin
                    if (!shed_mode)
                        state <= LS_IDLE;
                    else if (close_due)
                    begin
                        close_cmd <= !trip_circuit_supervision_failure;
                        close_command_annulled <= trip_circuit_supervision_failure;
                        state <= LS_IDLE;
                    end
                end
                default: state <= LS_IDLE;
            endcase
        end
    end

    // sticky event bits: a new event wins over a same-cycle write-one clear
    wire [3:0] events = {uv_at_pickup & ~uv_pick, close_command_annulled, close_cmd, open_cmd};
    wire [3:0] clr_mask = (wr_en && hit_ist) ? pwdata[3:0] : 4'h0;
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            int_stat <= RST_INT;
        else
            int_stat <= (int_stat & ~clr_mask) | events;
    end
    assign irq = |(int_stat & int_mask);

    // read mux
    wire [31:0] status_word = {26'h0, state, shed_latched, uv_pick, element_trip};
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hit_ctrl) prdata = {25'h0, ctrl};
        if (hit_blk) prdata = {20'h0, blk_sel};
        if (hit_uv) prdata = {16'h0, uv_set};
        if (hit_tim) prdata = {20'h0, reset_cyc, 3'h0, act_half};
        if (hit_of) prdata = {16'h0, of1_set};
        if (hit_uf) prdata = {16'h0, uf1_set};
        if (hit_roc) prdata = {roc1_rate, roc1_freq};
        if (hit_stat) prdata = status_word;
        if (hit_ist) prdata = {28'h0, int_stat};
        if (hit_imk) prdata = {28'h0, int_mask};
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_b);

    a_block_keeps_off: assert property ((|elem_block) |=> ((element_trip & $past(elem_block)) == 3'h0))
        else $error("blocked element tripped");
    a_uv_inhibits_all: assert property (uv_pick |=> (element_trip == 3'h0))
        else $error("element tripped under undervoltage");
    a_uv_pickup_level: assert property (uv_at_pickup |=> uv_pick)
        else $error("supervisor failed to pick up");
    a_uv_reset_count: assert property ($fell(uv_pick) |-> $past(uv_cnt) == UV_RESET_CYCLES && $past(uv_above_reset))
        else $error("supervisor reset early");
    a_low_volt_idle: assert property (below_min |=> (element_trip == 3'h0))
        else $error("element tripped below minimum voltage");
    a_open_permitted: assert property (open_cmd |-> $past(permit) && $past(shed_src))
        else $error("open issued without permission");
    // shed mode must have been on last cycle too: a plain overfrequency trip may still stand when it is switched on
    a_of_gated_shed: assert property ((element_trip[EL_OF] && shed_mode && $past(shed_mode))
        |-> $past(shed_latched && breaker_open_status))
        else $error("overfrequency active without shed latch");
    a_close_annulled: assert property (close_command_annulled |-> !close_cmd && $past(trip_circuit_supervision_failure))
        else $error("annulment without supervision failure");
    a_close_single: assert property (close_cmd |=> !close_cmd && state == LS_IDLE)
        else $error("close not a single pulse");
    a_rearm_after: assert property ((state == LS_SHED && close_due) |=> state == LS_IDLE ##1 !shed_latched)
        else $error("controller did not re-arm");

    // command pulses, shed latch, gating of the restoring element, late blocking and supervisor levels
    a_open_single: assert property (open_cmd |=> !open_cmd)
        else $error("open not a single pulse");

    a_annul_single: assert property (close_command_annulled |=> !close_command_annulled)
        else $error("annulment not a single pulse");

    a_open_latches: assert property (open_cmd |-> shed_latched)
        else $error("open issued without latching the shed step");

    a_close_gated: assert property (close_cmd |-> $past(permit && breaker_open_status && shed_latched))
        else $error("close issued without latch, open breaker or permission");

    a_close_no_fail: assert property (close_cmd |-> !$past(trip_circuit_supervision_failure))
        else $error("close issued during supervision failure");

    a_fail_suppress: assert property ((shed_latched && shed_mode && close_due && trip_circuit_supervision_failure)
        |=> close_command_annulled && !close_cmd)
        else $error("close not replaced by annulment");

    a_of_latch_reset: assert property ((element_trip[EL_OF] && shed_mode && !shed_latched) |=> !element_trip[EL_OF])
        else $error("overfrequency trip kept after latch cleared");

    a_of_pickup_held: assert property ((shed_mode && !shed_latched) |=> g_el[EL_OF].pk_cnt == 5'h00)
        else $error("overfrequency pickup counted without shed latch");

    a_late_block_clear: assert property ((element_trip[EL_UF] && elem_block[EL_UF]) |=> !element_trip[EL_UF])
        else $error("blocked underfrequency trip not reset");

    a_uv_rise_level: assert property ($rose(uv_pick) |-> $past(uv_at_pickup))
        else $error("supervisor picked up above the setting");

    a_uv_dip_holds: assert property ((uv_pick && !uv_above_reset) |=> uv_pick)
        else $error("supervisor reset below 105 percent");
endmodule

// ---- rtl/fls_pkg.sv ----
package fls_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BLK_SEL = 8'h04;
    localparam logic [7:0] OFS_UV_SET = 8'h08;
    localparam logic [7:0] OFS_TIMING = 8'h0c;
    localparam logic [7:0] OFS_OF1_SET = 8'h10;
    localparam logic [7:0] OFS_UF1_SET = 8'h14;
    localparam logic [7:0] OFS_ROC1_SET = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_INT_STAT = 8'h20;
    localparam logic [7:0] OFS_INT_MASK = 8'h24;

    // values after reset (voltage in 0.1 V, frequency in 10 mHz, rate in 10 mHz/s)
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [11:0] RST_BLK_SEL = 12'h000;
    localparam logic [15:0] RST_UV_SET = 16'h0014;
    localparam logic [4:0] RST_ACT_HALF = 5'h06;
    localparam logic [3:0] RST_RESET_CYC = 4'h0;
    localparam logic [15:0] RST_OF1_SET = 16'h1b58;
    localparam logic [15:0] RST_UF1_SET = 16'h0fa0;
    localparam logic [15:0] RST_ROC1_FREQ = 16'h0fa0;
    localparam logic [15:0] RST_ROC1_RATE = 16'hff9c;
    localparam logic [3:0] RST_INT = 4'h0;

    // field positions
    localparam int TIM_RESET_LSB = 8;
    localparam int ROC_RATE_LSB = 16;

    // measurement limits and counts
    localparam logic [15:0] MIN_FREQ_VOLTAGE = 16'h0014;
    localparam logic [3:0] UV_RESET_CYCLES = 4'ha;
    localparam logic [4:0] UV_RESET_PCT = 5'h15;
    localparam logic [4:0] UV_BASE_PCT = 5'h14;
    localparam logic [15:0] FREQ_HYST = 16'h0001;
    localparam logic [4:0] ROC_MIN_HALF = 5'h0a;

    // element indices
    localparam int EL_OF = 0;
    localparam int EL_UF = 1;
    localparam int EL_ROC = 2;
    localparam int NUM_EL = 3;

    // interrupt bit positions
    localparam int EV_OPEN = 0;
    localparam int EV_CLOSE = 1;
    localparam int EV_ANNUL = 2;
    localparam int EV_UV = 3;

    typedef enum logic [0:0] {
        LS_IDLE = 1'b0,
        LS_SHED = 1'b1
    } ls_state_t;

    typedef struct packed {
        logic [2:0] elem_en;
        logic freq_src_vab;
        logic shed_type_roc;
        logic shed_en;
        logic switching_permission;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] freq;
    } meas_t;
endpackage

// ---- tb/breaker_model.sv ----
`timescale 1ns/1ps
// far-side circuit breaker: moves only after a travel time, so the controller
// cannot count on an instant change of position after its own command
module breaker_model
#(
    parameter int DLY = 6
)
(
    input wire logic clk_sys,
    input wire logic open_cmd,
    input wire logic close_cmd,
    output logic breaker_open_status = 1'b0
);
    int remain = 0;
    logic target = 1'b0;

    // a new command restarts the travel time; position changes when it runs out
    always @(posedge clk_sys)
    begin
        if (open_cmd === 1'b1 || close_cmd === 1'b1)
        begin
            target <= open_cmd;
            remain <= DLY;
        end
        else if (remain > 0)
        begin
            remain <= remain - 1;
            if (remain == 1)
                breaker_open_status <= target;
        end
    end
endmodule

// ---- tb/frequency_load_shedding_control_test.sv ----
`timescale 1ns/1ps
module frequency_load_shedding_control_test
    import fls_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err_seen, irq, breaker_open_status;
    logic [7:0] contact_inputs = 8'h00;
    meas_t meas_va = '0, meas_vab = '0;
    logic [15:0] rate_of_change = 16'h0000;
    logic half_cycle_tick = 1'b0, cycle_tick = 1'b0, trip_circuit_supervision_failure = 1'b0;
    logic [2:0] element_trip;
    logic [2:0] tick_cnt = 3'h0;
    logic frequency_elements_blocked, open_cmd, close_cmd, close_command_annulled;
    int err_total = 0, comparisons = 0, n_open = 0, n_close = 0, n_annul = 0;

    always #20 clk_sys = ~clk_sys;

    // power cycle shortened to 8 clocks so the supervisor counts stay cheap
    always @(posedge clk_sys)
    begin
        tick_cnt <= tick_cnt + 3'h1;
        half_cycle_tick <= (tick_cnt[1:0] == 2'h3);
        cycle_tick <= (tick_cnt == 3'h7);
    end

    // pulse counters: a pulse longer than one cycle counts once per cycle
    always @(posedge clk_sys)
    begin
        if (open_cmd === 1'b1) n_open <= n_open + 1;
        if (close_cmd === 1'b1) n_close <= n_close + 1;
        if (close_command_annulled === 1'b1) n_annul <= n_annul + 1;
    end

    frequency_load_shedding_control i_frequency_load_shedding_control (.clk_sys(clk_sys), .rst_b(rst_b),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .contact_inputs(contact_inputs), .meas_va(meas_va),
        .meas_vab(meas_vab), .rate_of_change(rate_of_change), .half_cycle_tick(half_cycle_tick),
        .cycle_tick(cycle_tick), .breaker_open_status(breaker_open_status),
        .trip_circuit_supervision_failure(trip_circuit_supervision_failure), .element_trip(element_trip),
        .frequency_elements_blocked(frequency_elements_blocked), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .close_command_annulled(close_command_annulled), .irq(irq));

    breaker_model #(.DLY(6)) i_breaker_model (.clk_sys(clk_sys), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .breaker_open_status(breaker_open_status));

    task chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("ERROR %0t ns: %s", $time, msg);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one transfer; request held until pready is seen at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        chk(pready === 1'b1, "no bus answer");
        if (pready !== 1'b1)
            end_of_test();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err_seen);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err, input string msg);
        apb(1'b0, a, 32'h0, rd, err_seen);
        chk(rd === exp && err_seen === exp_err, msg);
    endtask

    // line-line input stays at 50 Hz so a wrong source choice shows up
    task set_meas(input logic [15:0] v, input logic [15:0] f);
        @(posedge clk_sys);
        meas_va <= '{voltage: v, freq: f};
        meas_vab <= '{voltage: v, freq: 16'h1388};
    endtask

    // 0/1 blocked low/high, 2/3 underfreq/overfreq trip low, 100+n: n pulses seen
    function automatic logic cond(input int w);
        case (w)
            0: return frequency_elements_blocked === 1'b0;
            1: return frequency_elements_blocked === 1'b1;
            2: return element_trip[1] === 1'b0;
            3: return element_trip[0] === 1'b0;
            4: return element_trip[0] === 1'b1;
            default: return (n_open + n_close + n_annul) == (w - 100);
        endcase
    endfunction

    task wait_cond(input int w, input int bound, input string msg);
        int i;
        i = 0;
        while (!cond(w) && i < bound)
        begin
            @(negedge clk_sys);
            i++;
        end
        chk(cond(w), msg);
        if (!cond(w))
            end_of_test();
    endtask

    task ticks(input int n);
        int got;
        got = 0;
        for (int k = 0; k < 8 * n + 8 && got < n; k++)
        begin
            @(negedge clk_sys);
            if (cycle_tick === 1'b1) got++;
        end
        chk(got == n, "cycle strobes missing");
        if (got != n)
            end_of_test();
    endtask

    task test_regs;
        logic [7:0] adr [6];
        logic [31:0] val [6];
        adr = '{OFS_CTRL, OFS_UV_SET, OFS_TIMING, OFS_OF1_SET, OFS_ROC1_SET, OFS_STATUS};
        val = '{32'h0, 32'h14, 32'h6, 32'h1b58, 32'hff9c0fa0, 32'h8};
        foreach (adr[k])
            rd_chk(adr[k], val[k], 1'b0, "register reset value");
        rd_chk(8'h40, 32'h0, 1'b1, "unmapped address not refused");
        chk(frequency_elements_blocked === 1'b1, "supervisor not picked after reset");
    endtask

    task test_uv;
        wr(OFS_UV_SET, 32'h64);
        set_meas(16'h00c8, 16'h1388);
        ticks(9);
        chk(frequency_elements_blocked === 1'b1, "supervisor released early");
        wait_cond(0, 12, "supervisor not released after ten cycles");
        set_meas(16'h0064, 16'h1388);
        wait_cond(1, 3, "no pickup at the setting");
        set_meas(16'h0068, 16'h1388);
        ticks(12);
        chk(frequency_elements_blocked === 1'b1, "released below 105 percent");
        set_meas(16'h0069, 16'h1388);
        wait_cond(0, 100, "not released at 105 percent");
    endtask

    // supervisor set to 1.0 V so only the measuring limit can inhibit
    task test_low_volt;
        wr(OFS_UV_SET, 32'ha);
        set_meas(16'h0013, 16'h1388);
        wait_cond(1, 3, "elements not inhibited below 2 V");
        set_meas(16'h0014, 16'h1388);
        wait_cond(0, 3, "elements inhibited at 2 V");
    endtask

    task test_shed;
        wr(OFS_CTRL, 32'h73);
        wr(OFS_BLK_SEL, 32'ha0);
        wr(OFS_INT_STAT, 32'hf);
        wr(OFS_INT_MASK, 32'h1);
        set_meas(16'h00c8, 16'h1bbc);
        repeat (40) @(negedge clk_sys);
        chk(element_trip[0] === 1'b0 && n_open == 0, "overfrequency ran unlatched");
        @(posedge clk_sys);
        contact_inputs <= 8'h04;
        set_meas(16'h00c8, 16'h0f3c);
        repeat (40) @(negedge clk_sys);
        chk(element_trip[1] === 1'b0 && n_open == 0, "blocked element tripped");
        @(posedge clk_sys);
        contact_inputs <= 8'h00;
        wait_cond(101, 40, "no open command");
        chk(element_trip[1] === 1'b1 && irq === 1'b1, "trip or interrupt missing");
        rd_chk(OFS_INT_STAT, 32'h1, 1'b0, "open event not recorded");
        wr(OFS_INT_STAT, 32'h1);
        @(negedge clk_sys);
        chk(irq === 1'b0, "interrupt not cleared");
        @(posedge clk_sys);
        contact_inputs <= 8'h04;
        wait_cond(2, 3, "trip kept after block");
        set_meas(16'h00c8, 16'h1bbc);
        wait_cond(102, 60, "no close command");
        wait_cond(3, 3, "overfrequency trip kept after latch cleared");
        repeat (20) @(negedge clk_sys);
        chk(n_open == 1 && n_close == 1 && n_annul == 0, "extra command pulses");
    endtask

    task test_rearm;
        @(posedge clk_sys);
        contact_inputs <= 8'h00;
        trip_circuit_supervision_failure <= 1'b1;
        set_meas(16'h00c8, 16'h0f3c);
        wait_cond(103, 60, "no second open after close");
        set_meas(16'h00c8, 16'h1bbc);
        wait_cond(104, 60, "no restoration attempt");
        chk(n_close == 1 && n_annul == 1, "close not annulled");
        wr(OFS_CTRL, 32'h72);
        @(posedge clk_sys);
        trip_circuit_supervision_failure <= 1'b0;
        set_meas(16'h00c8, 16'h0f3c);
        repeat (60) @(negedge clk_sys);
        chk(n_open == 2, "open without permission");
    endtask

    // line-line source sits at 50 Hz, so the tripped underfrequency must drop once it is chosen
    task test_roc;
        wr(OFS_CTRL, 32'h7f);
        wait_cond(2, 3, "source not switched to line-line");
        wr(OFS_CTRL, 32'h77);
        repeat (40) @(negedge clk_sys);
        chk(element_trip[1] === 1'b1 && n_open == 2, "underfrequency opened in rate mode");
        @(posedge clk_sys);
        rate_of_change <= 16'hff00;
        wait_cond(105, 60, "no open on rate trip");
        chk(element_trip[2] === 1'b1, "rate element not tripped");
    endtask

    // shedding off: overfrequency 1 is a plain element with a two-cycle reset time
    task test_of_reset;
        wr(OFS_CTRL, 32'h71);
        wr(OFS_TIMING, 32'h206);
        set_meas(16'h00c8, 16'h1b58);
        wait_cond(4, 40, "overfrequency did not pick up at the setting");
        set_meas(16'h00c8, 16'h1b4d);
        ticks(1);
        chk(element_trip[0] === 1'b1, "overfrequency reset before the reset time");
        wait_cond(3, 24, "overfrequency did not reset");
    endtask

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_regs();
        test_uv();
        test_low_volt();
        test_shed();
        test_rearm();
        test_roc();
        test_of_reset();
        end_of_test();
    end

    // hang guard: 100000 clock periods
    initial
    begin
        #4000000;
        err_total++;
        $display("ERROR %0t ns: run did not finish", $time);
        end_of_test();
    end
endmodule
